// ===== logic/tcp_config_page.sv
`timescale 1ns/10ps
// How it works
// R1: page code must be 10h
// R2: page length must be 0Dh
// R3: page taken only with page-format flag set
// R4: change-format flag gates gap threshold update
// R5: gap threshold is bits 2..0, 4..3 reserved
// R6: after threshold gap blocks, resume or stop
// R7: fill track, then one or two gap tracks (code always writes one gap track)
// R8: threshold clamps above 07h, resets 07h
// R9: latest page of two sets gap threshold
// R10: initiator changes threshold only when needed
// R11: unsupported fields must be zero
// R12: write fill level 20h..D0h, reset 80h
// R13: read drain level same range and default
// R14: unequal ratios give illegal request
// R15: ratios shared with vendor motion threshold
// R16: 100 ms timer flushes partial buffer
// R17: zero delay disables timed flush
// R18: delay saturates at 3FFFh silently
// R19: three capability bits always read one
// R20: early warning on write flushes buffer
// R21: read early warning reported if enabled
// R22: warning: no sense, medium end set
// R23: bad page rejected, parameters unchanged
module tcp_config_page
	import tcp_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYC
) (
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	input  wire logic        sel_start_i,      // page transfer begins
	input  wire logic        sel_pf_i,         // page-format flag of command
	input  wire logic        sel_valid_i,      // page byte strobe
	input  wire logic [7:0]  sel_data_i,       // page byte
	input  wire logic        sel_end_i,        // page transfer complete
	input  wire logic        vnd_valid_i,      // vendor page applied
	input  wire logic [7:0]  vnd_gap_i,        // vendor gap threshold
	input  wire logic [7:0]  vnd_motion_i,     // vendor motion threshold
	input  wire logic        sense_req_i,      // read one page byte
	input  wire logic [3:0]  sense_addr_i,     // byte index
	input  wire logic        wr_cmd_done_i,    // write command ended
	input  wire logic [7:0]  buf_level_i,      // buffer fill, 4 KB units
	input  wire logic        buf_empty_i,      // nothing to write
	input  wire logic        gap_block_done_i, // one gap block written
	input  wire logic        track_end_i,      // current track finished
	input  wire logic        data_writing_i,   // write operation active
	input  wire logic        rd_cmd_done_i,    // read command ended
	input  wire logic        early_warning_position_i,
	output logic             sel_done_o,       // page verdict or read early warning report pulse
	output logic             check_cond_o,     // check condition with verdict
	output logic [3:0]       sense_key_o,      // sense key of verdict
	output logic             end_of_medium_bit_o,
	output logic             beginning_of_tape_bit_o,
	output logic             physical_end_bit_o,
	output logic             sense_valid_o,    // sense byte ready
	output logic [7:0]       sense_data_o,     // sense byte
	output logic [2:0]       gap_threshold_o,  // threshold in use
	output logic [7:0]       motion_level_o,   // fill and drain level
	output logic             flush_o,          // write buffer to tape: timer pulse, held during write early warning
	output logic             write_gap_o,      // write a gap block
	output logic             tape_stop_o       // stop tape pulse
);
	// elaboration check: the tick divider must give a one-cycle pulse
	if (TICK_DIV < 2) $error("bad tick divider");

	// shadow of the incoming page
	logic [3:0]  idx;          // next byte index
	logic [7:0]  s_code, s_len, s_fmt, s_wfill, s_rdrain, s_dhi, s_dlo;
	logic        s_bad;        // nonzero unsupported field or extra byte seen
	logic        s_pf;         // page-format flag latched
	// live parameters
	logic [2:0]  gap_thr;
	logic [7:0]  ratio;
	logic [15:0] dly;
	logic        report_warning_read_flag;          // report early warning on reads
	logic        feat_rew;     // report early warning bit from the page

	// decode of the byte under capture
	wire logic bad_fmt  = (idx == OFS_FMT)  && (sel_data_i[7:6] != 2'b00);           // R11
	wire logic bad_part = (idx == OFS_PART) && (sel_data_i != 8'h00);                // R11
	wire logic bad_feat = (idx == OFS_FEAT) && (sel_data_i[7] | sel_data_i[5] |
		sel_data_i[4] | sel_data_i[3] | sel_data_i[2] | sel_data_i[1]);            // R11
	wire logic bad_gap  = (idx == OFS_GAP)  && (sel_data_i != 8'h00);                // R11
	wire logic bad_eod  = (idx == OFS_EOD)  && (sel_data_i[7:5] != 3'b000);          // R11
	wire logic bad_tail = (idx > OFS_EOD) && (idx <= OFS_COMP) && (sel_data_i != 8'h00); // R11
	wire logic bad_byte = bad_fmt | bad_part | bad_feat | bad_gap | bad_eod | bad_tail;

	// verdict on page end
	wire logic code_ok  = (s_code[5:0] == PAGE_CODE[5:0]);                            // R1
	wire logic len_ok   = (s_len == PAGE_LEN) && (idx == PAGE_BYTES);                  // R2
	wire logic ratio_eq = (s_wfill == s_rdrain);                                      // R14
	wire logic ratio_in = (s_wfill >= RATIO_MIN) && (s_wfill <= RATIO_MAX);           // R12 R13
	wire logic page_ok  = s_pf && code_ok && len_ok && !s_bad && ratio_eq && ratio_in; // R3 R23
	wire logic [7:0]  gap_req  = {3'b000, s_fmt[4:0]} & 8'h07;                      // R5
	wire logic [15:0] dly_req  = {s_dhi, s_dlo};
	wire logic [15:0] dly_sat  = (dly_req > DLY_MAX) ? DLY_MAX : dly_req;             // R18
	wire logic [7:0]  vgap_sat = (vnd_gap_i > GAP_MAX) ? GAP_MAX : vnd_gap_i;         // R8
	wire logic apply = sel_end_i && page_ok;

	// capture of page bytes
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			idx <= 4'h0;
			s_code <= 8'h00;
			s_len <= 8'h00;
			s_fmt <= 8'h00;
			s_wfill <= 8'h00;
			s_rdrain <= 8'h00;
			s_dhi <= 8'h00;
			s_dlo <= 8'h00;
			s_bad <= 1'b0;
			s_pf <= 1'b0;
		end else if (sel_start_i) begin
			idx <= 4'h0;
			s_bad <= 1'b0;
			s_pf <= sel_pf_i; // R3
		end else if (sel_valid_i) begin
			if (idx == OFS_CODE) s_code <= sel_data_i;
			if (idx == OFS_LEN) s_len <= sel_data_i;
			if (idx == OFS_FMT) s_fmt <= sel_data_i;
			if (idx == OFS_WFILL) s_wfill <= sel_data_i;
			if (idx == OFS_RDRAIN) s_rdrain <= sel_data_i;
			if (idx == OFS_DLY_HI) s_dhi <= sel_data_i;
			if (idx == OFS_DLY_LO) s_dlo <= sel_data_i;
			if (bad_byte) s_bad <= 1'b1;
			// extra bytes mark the page bad
			if (idx != 4'hF) idx <= idx + 4'h1;
			else s_bad <= 1'b1;
		end
	end

	// live parameters: newest of the two pages wins; the configuration page wins when both arrive in one cycle
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			gap_thr <= GAP_RST;   // R8
			ratio <= RATIO_RST;   // R12
			dly <= DLY_RST;       // R17
			report_warning_read_flag <= 1'b0;          // R21
		end else if (apply) begin
			if (s_fmt[5]) gap_thr <= gap_req[2:0]; // R4 R9
			ratio <= s_wfill;                      // R15
			dly <= dly_sat;                        // R18
			report_warning_read_flag <= feat_rew;
		end else if (vnd_valid_i) begin
			gap_thr <= vgap_sat[2:0];              // R9 R8
			if (vnd_motion_i >= RATIO_MIN && vnd_motion_i <= RATIO_MAX)
				ratio <= vnd_motion_i;             // R15
		end
	end
	// report early warning bit taken as the page streams past
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) feat_rew <= 1'b0;
		else if (sel_valid_i && idx == OFS_FEAT) feat_rew <= sel_data_i[0];
	end

	// 100 ms tick source
	logic tick;
	tcp_tick #(.DIV(TICK_DIV)) u_tick (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.tick_o    (tick)
	);

	// flush timer
	logic        tmr_run;
	logic [15:0] tmr_cnt;
	wire logic tmr_hit = tmr_run && tick && (dly != 16'h0) && (tmr_cnt + 16'h1 >= dly); // R16 R17
	wire logic ew_hit  = early_warning_position_i && data_writing_i;        // R20
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tmr_run <= 1'b0;
			tmr_cnt <= 16'h0;
			flush_o <= 1'b0;
		end else begin
			flush_o <= tmr_hit | ew_hit;                                    // R20
			if (wr_cmd_done_i && buf_level_i < ratio && dly != 16'h0) begin // R16 R17
				tmr_run <= 1'b1;
				tmr_cnt <= 16'h0;
			end else if (tmr_hit || ew_hit || dly == 16'h0) begin           // R17
				tmr_run <= 1'b0;
			end else if (tmr_run && tick) begin
				tmr_cnt <= tmr_cnt + 16'h1;
			end
		end
	end

	// gap writer: threshold blocks, then fill track and one gap track
	tcp_wst_t    wst, next_wst;
	logic [2:0]  gcnt;       // gap blocks so far
	logic [1:0]  trk;        // gap tracks written
	always_comb begin
		next_wst = wst;
		case (wst)
			TCP_IDLE:   if (data_writing_i) next_wst = TCP_DATA;
			TCP_DATA:   if (buf_empty_i) next_wst = TCP_GAPS;
			TCP_GAPS: begin // R6
				if (!buf_empty_i) next_wst = TCP_DATA;
				else if (gap_block_done_i && gcnt + 3'h1 >= gap_thr) next_wst = TCP_FILL;
				else if (gap_thr == 3'h0) next_wst = TCP_FILL;
			end
			TCP_FILL:   if (track_end_i) next_wst = TCP_TRACKS;            // R7
			TCP_TRACKS: if (track_end_i && trk == 2'h0) next_wst = TCP_IDLE; // R7
			default:    next_wst = TCP_IDLE;
		endcase
	end
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wst <= TCP_IDLE;
			gcnt <= 3'h0;
			trk <= 2'h0;
			write_gap_o <= 1'b0;
			tape_stop_o <= 1'b0;
		end else begin
			wst <= next_wst;
			gcnt <= (wst == TCP_GAPS && gap_block_done_i) ? gcnt + 3'h1 :
				(wst == TCP_GAPS) ? gcnt : 3'h0;
			trk <= (wst == TCP_TRACKS && track_end_i) ? trk + 2'h1 :
				(wst == TCP_TRACKS) ? trk : 2'h0;
			write_gap_o <= (next_wst == TCP_GAPS) || (next_wst == TCP_FILL) ||
				(next_wst == TCP_TRACKS);
			tape_stop_o <= (wst == TCP_TRACKS) && (next_wst == TCP_IDLE);
		end
	end

	// verdicts and early warning status
	logic rd_ew_pend; // warning seen during read
	wire logic ew_rd_set = early_warning_position_i && !data_writing_i && report_warning_read_flag; // R21
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sel_done_o <= 1'b0;
			check_cond_o <= 1'b0;
			sense_key_o <= SK_NO_SENSE;
			end_of_medium_bit_o <= 1'b0;
			beginning_of_tape_bit_o <= 1'b0;
			physical_end_bit_o <= 1'b0;
			rd_ew_pend <= 1'b0;
		end else begin
			sel_done_o <= sel_end_i | (rd_cmd_done_i & rd_ew_pend);
			if (ew_rd_set)
				rd_ew_pend <= 1'b1;                                 // R21
			if (sel_end_i) begin
				check_cond_o <= !page_ok;                          // R14 R23
				sense_key_o <= page_ok ? SK_NO_SENSE : SK_ILLEGAL;  // R14
				end_of_medium_bit_o <= 1'b0;
			end else if (rd_cmd_done_i && rd_ew_pend) begin
				if (!ew_rd_set) rd_ew_pend <= 1'b0; // a fresh warning wins over the report
				check_cond_o <= 1'b1;                              // R22
				sense_key_o <= SK_NO_SENSE;                         // R22
				end_of_medium_bit_o <= 1'b1;                       // R22
				beginning_of_tape_bit_o <= 1'b0;
				physical_end_bit_o <= 1'b0;
			end
		end
	end

	// sense readback
	logic [7:0] sense_mux;
	always_comb begin
		case (sense_addr_i)
			OFS_CODE:   sense_mux = PAGE_CODE;                             // R1
			OFS_LEN:    sense_mux = PAGE_LEN;                              // R2
			OFS_FMT:    sense_mux = {5'b00000, gap_thr};
			OFS_WFILL:  sense_mux = ratio;
			OFS_RDRAIN: sense_mux = ratio;
			OFS_DLY_HI: sense_mux = dly[15:8];
			OFS_DLY_LO: sense_mux = dly[7:0];
			OFS_FEAT:   sense_mux = {1'b0, 1'b1, 5'b00000, report_warning_read_flag};          // R19
			OFS_EOD:    sense_mux = 8'h18;                                // R19
			default:    sense_mux = 8'h00;
		endcase
	end
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sense_valid_o <= 1'b0;
			sense_data_o <= 8'h00;
		end else begin
			sense_valid_o <= sense_req_i;
			sense_data_o <= sense_mux;
		end
	end
	assign gap_threshold_o = gap_thr;
	assign motion_level_o = ratio;

	// checks on page verdicts and stored values
	chk_bad_keeps: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R23
		sel_end_i && !page_ok |=> $stable(ratio) && $stable(dly))
		else $error("rejected page changed parameters");
	chk_ratio_key: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R14
		sel_end_i && !ratio_eq |=> check_cond_o && sense_key_o == SK_ILLEGAL)
		else $error("unequal ratios not rejected");
	chk_pf_need: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R3
		sel_end_i && !s_pf |=> check_cond_o)
		else $error("page taken without page format");
	chk_code_need: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R1
		sel_end_i && s_code[5:0] != PAGE_CODE[5:0] |=> check_cond_o)
		else $error("wrong page code not rejected");
	chk_len_need: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R2
		sel_end_i && s_len != PAGE_LEN |=> check_cond_o && sense_key_o == SK_ILLEGAL)
		else $error("wrong page length not rejected");
	chk_apply_values: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R15
		apply |=> ratio == $past(s_wfill) && dly == $past(dly_sat))
		else $error("accepted page not applied");
	// gap threshold from either page
	chk_gap_clamp: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R8
		vnd_valid_i && !apply && vnd_gap_i > GAP_MAX |=> gap_thr == GAP_RST)
		else $error("gap threshold not clamped");
	chk_caf_gate: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R4
		apply && !s_fmt[5] && !vnd_valid_i |=> $stable(gap_thr))
		else $error("gap changed without format flag");
	// flush timer and early warning
	chk_dly_sat: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R18
		dly <= DLY_MAX)
		else $error("delay above limit");
	chk_zero_nofl: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R17
		dly == 16'h0 && !ew_hit |=> !flush_o)
		else $error("flush with zero delay");
	chk_ew_flush: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R20
		ew_hit |=> flush_o)
		else $error("no flush at early warning");
	chk_ew_report: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R22
		rd_cmd_done_i && rd_ew_pend && !sel_end_i |=> end_of_medium_bit_o
		&& !physical_end_bit_o && sense_key_o == SK_NO_SENSE)
		else $error("early warning sense wrong");
	// gap writer sequence
	chk_gap_resume: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R6
		wst == TCP_GAPS && !buf_empty_i |=> wst == TCP_DATA)
		else $error("new data did not resume writing");
	chk_track_after_fill: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R7
		wst == TCP_FILL && track_end_i |=> wst == TCP_TRACKS && write_gap_o)
		else $error("no gap track after track fill");
	// fixed capability bit 6 of the feature byte in the readback
	chk_caps_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R19
		sense_req_i && sense_addr_i == OFS_FEAT |=> sense_data_o[6] && !sense_data_o[7])
		else $error("capability bit not reported");
	// coverage of the main scenarios
	cov_apply: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) apply);
	cov_flush: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) tmr_hit);
	cov_stop: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) tape_stop_o);
	cov_reject: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) sel_end_i && !page_ok);
	cov_ew_read: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) rd_cmd_done_i && rd_ew_pend);
endmodule

// ===== logic/tcp_pkg.sv
package tcp_pkg;
	// page layout
	localparam logic [7:0]  PAGE_CODE      = 8'h10;
	localparam logic [7:0]  PAGE_LEN       = 8'h0D;
	localparam logic [3:0]  PAGE_BYTES     = 4'hF;
	localparam logic [3:0]  OFS_CODE       = 4'h0;
	localparam logic [3:0]  OFS_LEN        = 4'h1;
	localparam logic [3:0]  OFS_FMT        = 4'h2;
	localparam logic [3:0]  OFS_PART       = 4'h3;
	localparam logic [3:0]  OFS_WFILL      = 4'h4;
	localparam logic [3:0]  OFS_RDRAIN     = 4'h5;
	localparam logic [3:0]  OFS_DLY_HI     = 4'h6;
	localparam logic [3:0]  OFS_DLY_LO     = 4'h7;
	localparam logic [3:0]  OFS_FEAT       = 4'h8;
	localparam logic [3:0]  OFS_GAP        = 4'h9;
	localparam logic [3:0]  OFS_EOD        = 4'hA;
	localparam logic [3:0]  OFS_COMP       = 4'hE;
	// reset values and limits
	localparam logic [2:0]  GAP_RST        = 3'h7;
	localparam logic [7:0]  GAP_MAX        = 8'h07;
	localparam logic [7:0]  RATIO_RST      = 8'h80;
	localparam logic [7:0]  RATIO_MIN      = 8'h20;
	localparam logic [7:0]  RATIO_MAX      = 8'hD0;
	localparam logic [15:0] DLY_RST        = 16'h0000;
	localparam logic [15:0] DLY_MAX        = 16'h3FFF;
	// sense keys
	localparam logic [3:0]  SK_NO_SENSE    = 4'h0;
	localparam logic [3:0]  SK_ILLEGAL     = 4'h5;
	// flush tick of 100 ms at 125 MHz
	localparam int          TICK_MS        = 100;
	localparam int          CLK_MHZ        = 125;
	localparam int          TICK_CYC       = TICK_MS * 1000 * CLK_MHZ;
	// writer states
	typedef enum logic [2:0] {
		TCP_IDLE, TCP_DATA, TCP_GAPS, TCP_FILL, TCP_TRACKS
	} tcp_wst_t;
endpackage

// ===== logic/tcp_tick.sv
`timescale 1ns/10ps
// divides the system clock into a one-cycle tick
module tcp_tick #(
	parameter int DIV = 12500000
) (
	input  wire logic clk_sys_i,
	input  wire logic sys_rst_i,
	output logic      tick_o
);
	// elaboration check: a divider below two cannot give a one-cycle tick
	if (DIV < 2) $error("tick divider too small");
	logic [31:0] cnt; // cycles since last tick
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt <= 32'h0;
			tick_o <= 1'b0;
		end else begin
			tick_o <= (cnt == 32'(DIV - 1));
			cnt <= (cnt == 32'(DIV - 1)) ? 32'h0 : cnt + 32'h1;
		end
	end
endmodule

// ===== dv/tcp_initiator.sv
`timescale 1ns/10ps
// initiator model: sends one configuration page per call
module tcp_initiator (
	input  wire logic       clk_sys_i,
	output logic            sel_start_o,
	output logic            sel_pf_o,
	output logic            sel_valid_o,
	output logic [7:0]      sel_data_o,
	output logic            sel_end_o
);
	// idle levels at time zero
	initial begin
		sel_start_o = 1'b0;
		sel_pf_o    = 1'b0;
		sel_valid_o = 1'b0;
		sel_data_o  = 8'h00;
		sel_end_o   = 1'b0;
	end
	// start, fifteen bytes from byte 0 upward, then end
	task automatic send_page(input logic pf, input logic [7:0] pg [15]);
		@(posedge clk_sys_i);
		sel_start_o <= 1'b1;
		sel_pf_o    <= pf;
		for (int i = 0; i < 15; i++) begin
			@(posedge clk_sys_i);
			sel_start_o <= 1'b0;
			sel_valid_o <= 1'b1;
			sel_data_o  <= pg[i];
		end
		@(posedge clk_sys_i);
		sel_valid_o <= 1'b0;
		sel_data_o  <= ~pg[14]; // released bus does not keep the last byte
		sel_end_o   <= 1'b1;
		@(posedge clk_sys_i);
		sel_end_o   <= 1'b0;
	endtask
endmodule

// ===== dv/tcp_config_page_tb.sv
`timescale 1ns/10ps
// self-checking bench for the configuration page handler
module tcp_config_page_tb import tcp_pkg::*; ;
	logic            clk_sys_i, sys_rst_i;
	wire logic       st, pf, sv, se;       // page transfer from the initiator
	wire logic [7:0] sd;
	logic            vv, sr, wcd, be, gbd, te, dw, rcd, ewp;
	logic [7:0]      vg, vm, bl;
	logic [3:0]      sa, sk;
	logic            sdone, cc, end_of_medium_bit, bot, physical_end_bit, svld, fl, wg, ts;
	logic [7:0]      sdat, mot;
	logic [2:0]      gth, g;
	logic [7:0]      pg [15];              // page under construction
	logic [8:0]      vq [$];               // expected verdicts, bit 8 = full compare
	logic [7:0]      sq [$];               // expected sense bytes
	logic [8:0]      ve;
	logic [3:0]      bi [9] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h9, 4'hE, 4'h8, 4'hA, 4'hC};
	logic [7:0]      bv [9] = '{8'h11, 8'h0C, 8'h01, 8'h41, 8'h01, 8'h01, 8'h80, 8'h80, 8'h01};
	int              errors, comparisons;
	logic [31:0]     rs;                   // xorshift state

	tcp_initiator tcp_initiator_i (.clk_sys_i(clk_sys_i), .sel_start_o(st), .sel_pf_o(pf),
		.sel_valid_o(sv), .sel_data_o(sd), .sel_end_o(se));
	tcp_config_page #(.TICK_DIV(10)) tcp_config_page_i (.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i), .sel_start_i(st), .sel_pf_i(pf), .sel_valid_i(sv),
		.sel_data_i(sd), .sel_end_i(se), .vnd_valid_i(vv), .vnd_gap_i(vg), .vnd_motion_i(vm),
		.sense_req_i(sr), .sense_addr_i(sa), .wr_cmd_done_i(wcd), .buf_level_i(bl),
		.buf_empty_i(be), .gap_block_done_i(gbd), .track_end_i(te), .data_writing_i(dw),
		.rd_cmd_done_i(rcd), .early_warning_position_i(ewp), .sel_done_o(sdone),
		.check_cond_o(cc), .sense_key_o(sk), .end_of_medium_bit_o(end_of_medium_bit),
		.beginning_of_tape_bit_o(bot), .physical_end_bit_o(physical_end_bit), .sense_valid_o(svld),
		.sense_data_o(sdat), .gap_threshold_o(gth), .motion_level_o(mot), .flush_o(fl),
		.write_gap_o(wg), .tape_stop_o(ts));

	// free-running system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] v);
		comparisons++;
		if (v !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, v);
		end
	endtask

	task automatic tally_and_finish();
		if (errors == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// verdict watcher: oldest note against each verdict pulse
	always @(posedge clk_sys_i) begin
		if (sdone === 1'b1) begin
			if (vq.size() == 0) chk("verdict", 16'h0, 16'h1);
			else begin
				ve = vq.pop_front();
				chk("verdict", {8'h0, ve[7:3]}, {8'h0, cc, sk});
				if (ve[8]) chk("sense bits", {13'h0, ve[2:0]}, {13'h0, end_of_medium_bit, bot, physical_end_bit});
			end
		end
	end

	// sense watcher
	always @(posedge clk_sys_i) begin
		if (svld === 1'b1) begin
			if (sq.size() == 0) chk("sense", 16'h0, 16'h1);
			else chk("sense", {8'h0, sq.pop_front()}, {8'h0, sdat});
		end
	end

	// builds a page; unsupported fields zero
	task automatic mk(input logic caf, input logic [2:0] gt, input logic [7:0] w, input logic [7:0] r,
		input logic [15:0] d, input logic report_warning_read_flag);
		foreach (pg[i]) pg[i] = 8'h00;
		pg[0] = 8'h10;
		pg[1] = 8'h0D;
		pg[2] = {2'b00, caf, 2'b00, gt};
		pg[4] = w;
		pg[5] = r;
		pg[6] = d[15:8];
		pg[7] = d[7:0];
		pg[8] = {7'h00, report_warning_read_flag};
	endtask

	task automatic send(input logic pfv, input logic bad);
		vq.push_back({1'b0, bad, bad ? 4'h5 : 4'h0, 3'b000});
		tcp_initiator_i.send_page(pfv, pg);
		repeat (2) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic sense(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		sr <= 1'b1;
		sa <= a;
		sq.push_back(e);
		@(posedge clk_sys_i);
		sr <= 1'b0;
		sa <= ~a;
		repeat (2) @(posedge clk_sys_i);
	endtask

	task automatic vendor(input logic [7:0] gv, input logic [7:0] mv);
		@(posedge clk_sys_i);
		vv <= 1'b1;
		vg <= gv;
		vm <= mv;
		@(posedge clk_sys_i);
		vv <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic wait_flush(input int lo, input int hi, input logic want);
		int n;
		n = 0;
		while (fl !== 1'b1 && n < hi) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		chk("flush", {15'h0, want}, {15'h0, (n >= lo && n < hi)});
	endtask

	task automatic wr_end();
		@(posedge clk_sys_i);
		bl  <= rnd() & 8'h1F;
		wcd <= 1'b1;
		@(posedge clk_sys_i);
		wcd <= 1'b0;
	endtask

	// watchdog
	initial begin
		#400000;
		errors++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		rs = 32'd71;
		errors = 0;
		comparisons = 0;
		sys_rst_i = 1'b1;
		{vv, sr, wcd, gbd, te, dw, rcd, ewp} = 8'h00;
		be = 1'b1;
		{vg, vm, bl, sa} = 28'h0;
		repeat (6) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_sys_i);
		#1;
		chk("gap", 16'h0007, gth);
		chk("ratio", 16'h0080, mot);
		sense(4'h4, 8'h80);
		sense(4'h5, 8'h80);
		sense(4'h7, 8'h00);
		sense(4'h8, 8'h40);
		sense(4'hA, 8'h18);
		vendor(8'h02, 8'h60);
		chk("gap", 16'h0002, gth);
		chk("ratio", 16'h0060, mot);
		g = 3'(rnd());
		mk(1'b1, g, 8'h40, 8'h40, 16'h0002, 1'b1);
		pg[8] = 8'h01;
		send(1'b1, 1'b0);
		chk("gap", {13'h0, g}, gth);
		chk("ratio", 16'h0040, mot);
		sense(4'h8, 8'h41);
		sense(4'h7, 8'h02);
		vendor(8'hFF, 8'h60);
		chk("gap", 16'h0007, gth);
		mk(1'b0, g ^ 3'h1, 8'h40, 8'h40, 16'h0002, 1'b1);
		send(1'b1, 1'b0);
		chk("gap", 16'h0007, gth);
		chk("ratio", 16'h0040, mot);
		wr_end();
		wait_flush(8, 40, 1'b1);
		// gap writer: resume on new data, then threshold, fill and gap track
		@(posedge clk_sys_i);
		dw <= 1'b1;
		be <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		dw <= 1'b0;
		be <= 1'b1;
		@(posedge clk_sys_i);
		#1;
		chk("gap write", 16'h0001, wg);
		@(posedge clk_sys_i);
		be <= 1'b0;
		@(posedge clk_sys_i);
		be <= 1'b1;
		#1;
		chk("gap write", 16'h0000, wg);
		repeat (7) begin
			@(posedge clk_sys_i);
			gbd <= 1'b1;
			@(posedge clk_sys_i);
			gbd <= 1'b0;
		end
		for (int t = 0; t < 2; t++) begin
			@(posedge clk_sys_i);
			te <= 1'b1;
			@(posedge clk_sys_i);
			te <= 1'b0;
			#1;
			chk("tape stop", 16'(t), ts);
			chk("gap write", 16'(1 - t), wg);
		end
		// write with early warning; buffer kept busy so no gaps start
		@(posedge clk_sys_i);
		dw  <= 1'b1;
		ewp <= 1'b1;
		be  <= 1'b0;
		wait_flush(0, 20, 1'b1);
		@(posedge clk_sys_i);
		dw  <= 1'b0;
		@(posedge clk_sys_i);
		vq.push_back({1'b1, 1'b1, 4'h0, 3'b100});
		rcd <= 1'b1;
		@(posedge clk_sys_i);
		rcd <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		ewp <= 1'b0;
		for (int k = 0; k < 12; k++) begin
			mk(1'b1, 3'h1, 8'h40, 8'h40, 16'h0002, 1'b1);
			if (k < 9) pg[bi[k]] = bv[k];
			if (k == 9) {pg[4], pg[5]} = 16'h1F1F;
			if (k == 10) {pg[4], pg[5]} = 16'hD1D1;
			send(k != 11, 1'b1);
			chk("gap", 16'h0007, gth);
			chk("ratio", 16'h0040, mot);
		end
		mk(1'b0, 3'h0, 8'h40, 8'h40, 16'hFFFF, 1'b0);
		send(1'b1, 1'b0);
		sense(4'h6, 8'h3F);
		sense(4'h7, 8'hFF);
		sense(4'h8, 8'h40);
		mk(1'b0, 3'h0, 8'h40, 8'h40, 16'h0000, 1'b0);
		send(1'b1, 1'b0);
		wr_end();
		wait_flush(0, 100, 1'b0);
		tally_and_finish();
	end
endmodule
